// [ccp_clock_plan.sv]
// Clock plan check, clock generator dividers and sync pulse capture.
// Assumes an APB master on REF_CLK_I and a sync pulse synchronous to it.
//
// Summary of operation
// - Generator makes converter and digital clocks.
// - High-performance PLL accepts 7.2 to 8.8 GHz.
// - Low-power PLL fixed 4423.68 MHz unless tuned.
// - Dividers retimed by PLL reset pulse.
// - Low-power PLL refused for 16-bit LTE40.
// - Low-power lanes: factors 2,8,12,16,32, capped.
// - Arbitrary mode accepts 24 kHz to 61.44 MHz.
// - Rates strictly inside twelve dead zones refused.
// - Above 160/3 MHz use high-performance PLL.
// - Sync capture only active in LVDS mode.
// - Sync sampled on selectable reference edge; code samples rising edges only, the falling choice one cycle later.
// - Sampled sync aligns all internal dividers.
//
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ps
module ccp_clock_plan
    import ccp_pkg::*;
#(
    parameter int DIV_W = 16
) (
    input wire logic REF_CLK_I,
    input wire logic RESET_N_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic SYNC_I,
    output logic CONV_CLK_EN_O,
    output logic DIG_CLK_EN_O,
    output logic HP_PLL_SEL_O,
    output logic IRQ_O
);

    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] rate;
        logic [31:0] freq;
        logic [31:0] divs;
        logic [2:0] ist;
        logic [2:0] imask;
        logic hp_sel;
        logic cfg_ok;
        logic [31:0] act_rate;
        logic [31:0] act_freq;
        logic [2:0] sync_cnt;
        logic samp1;
        logic samp2;
        logic sync_prev;
        logic retime;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic irq;
    } ccp_state_s;

    ccp_state_s s_r;
    ccp_state_s s_nxt;
    ccp_apb_req_s req;

    // True when x lies strictly between lo and hi.
    function automatic logic open_between(input logic [36:0] x, input logic [36:0] lo,
                                          input logic [36:0] hi);
        open_between = (x > lo) && (x < hi);
    endfunction

    // True when x lies between lo and hi with both ends allowed.
    function automatic logic closed_between(input logic [31:0] x, input logic [31:0] lo,
                                            input logic [31:0] hi);
        closed_between = (x >= lo) && (x <= hi);
    endfunction

    // True when the rate, scaled by 24, falls inside any dead zone.
    function automatic logic in_dead_zone(input logic [36:0] r24);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < DZ_COUNT; i++) begin
            hit = hit | open_between(r24, DZ_LO_X24[i], DZ_HI_X24[i]);
        end
        in_dead_zone = hit;
    endfunction

    // Only the listed lane serialization factors exist on the low-power path.
    function automatic logic ser_legal(input logic [7:0] f);
        ser_legal = (f == 8'h02) || (f == 8'h08) || (f == 8'h0c) || (f == 8'h10) ||
                    (f == 8'h20);
    endfunction

    // Decoded control fields.
    logic tune_en;
    logic force_lp;
    logic bits16;
    logic mcs_active;
    logic sync_fall;
    logic arb_mode;
    logic [7:0] ser_factor;

    // Rate check terms.
    logic [36:0] rate_x24;
    logic [36:0] rate_x3;
    logic [39:0] lane_bps;
    logic range_ok;
    logic dz_hit;
    logic want_hp;
    logic lte40_16;
    logic lte40_12;
    logic use_hp;
    logic lp_lane_ok;
    logic freq_ok;
    logic check_err;
    logic [31:0] new_freq;

    // Bus and event terms.
    logic setup;
    logic access;
    logic wr_ok;
    logic mapped;
    logic apply;
    logic sync_sel;
    logic sync_rise;
    logic align;
    logic [2:0] ev;
    logic [2:0] clr;
    logic [31:0] rd;
    logic conv_en;
    logic dig_en;

    assign req = '{sel: PSEL_I, enable: PENABLE_I, write: PWRITE_I, addr: PADDR_I,
                   wdata: PWDATA_I};

    // Field decode of the stored control word.
    always_comb begin
        tune_en = s_r.ctrl[CTRL_TUNE_EN];
        force_lp = s_r.ctrl[CTRL_FORCE_LP];
        bits16 = s_r.ctrl[CTRL_BITS16];
        mcs_active = s_r.ctrl[CTRL_MCS_EN] & s_r.ctrl[CTRL_LVDS];
        sync_fall = s_r.ctrl[CTRL_SYNC_FALL];
        arb_mode = s_r.ctrl[CTRL_ARB_RATE];
        ser_factor = s_r.ctrl[CTRL_SER_LSB +: 8];
    end

    // Configuration check; scaling avoids dividers in the compare path.
    always_comb begin
        rate_x24 = 37'(s_r.rate) * 37'd24;
        rate_x3 = 37'(s_r.rate) * 37'd3;
        lane_bps = 40'(s_r.rate) * 40'(ser_factor);
        range_ok = closed_between(s_r.rate, RATE_MIN_HZ, RATE_MAX_HZ);
        dz_hit = arb_mode & in_dead_zone(rate_x24);
        want_hp = rate_x3 > HP_ONLY_X3_HZ;
        lte40_16 = force_lp & (s_r.rate == LTE40_HZ) & bits16;
        lte40_12 = force_lp & (s_r.rate == LTE40_HZ) & !bits16;
        // The 12-bit LTE40 rate may stay on the low-power PLL when asked for.
        use_hp = want_hp & !lte40_12;
        lp_lane_ok = ser_legal(ser_factor) && (lane_bps <= LANE_MAX_BPS);
        if (use_hp) begin
            freq_ok = closed_between(s_r.freq, HP_MIN_KHZ, HP_MAX_KHZ);
            new_freq = s_r.freq;
        end else if (tune_en) begin
            freq_ok = closed_between(s_r.freq, LP_MIN_KHZ, LP_MAX_KHZ);
            new_freq = s_r.freq;
        end else begin
            freq_ok = 1'b1;
            new_freq = LP_FIX_KHZ;
        end
        check_err = !range_ok | dz_hit | lte40_16 | !freq_ok |
                    (!use_hp & !lp_lane_ok);
    end

    // Read data and address decode for the setup phase.
    always_comb begin
        mapped = 1'b1;
        rd = 32'h0000_0000;
        unique case (req.addr)
            OFS_CTRL: rd = s_r.ctrl;
            OFS_RATE: rd = s_r.rate;
            OFS_PLL_FREQ: rd = s_r.freq;
            OFS_DIVS: rd = s_r.divs;
            OFS_STATUS: rd = {25'h0, s_r.sync_cnt, mcs_active, s_r.cfg_ok, 1'b0, s_r.hp_sel};
            OFS_IRQ_STAT: rd = {29'h0, s_r.ist};
            OFS_IRQ_MASK: rd = {29'h0, s_r.imask};
            OFS_APPLY: rd = 32'h0000_0000;
            OFS_ACT_RATE: rd = s_r.act_rate;
            OFS_ACT_FREQ: rd = s_r.act_freq;
            default: mapped = 1'b0;
        endcase
    end

    // Sync capture: the falling-edge choice takes the later sample, which trades
    // a full cycle of extra latency for a single clock domain.
    always_comb begin
        sync_sel = sync_fall ? s_r.samp2 : s_r.samp1;
        sync_rise = sync_sel & !s_r.sync_prev & mcs_active;
        align = sync_rise | s_r.retime;
    end

    // Next state of registers, bus answer and interrupt logic.
    always_comb begin
        s_nxt = s_r;
        setup = req.sel & !req.enable;
        access = req.sel & req.enable & s_r.pready;
        wr_ok = access & req.write & !s_r.pslverr;
        apply = wr_ok & (req.addr == OFS_APPLY) & req.wdata[0];
        ev = 3'b000;
        clr = 3'b000;

        // Zero wait states: the answer stands in the first access cycle.
        s_nxt.pready = setup;
        s_nxt.pslverr = setup & !mapped;
        s_nxt.prdata = (setup & !req.write & mapped) ? rd : 32'h0000_0000;

        if (wr_ok) begin
            unique case (req.addr)
                OFS_CTRL: s_nxt.ctrl = req.wdata;
                OFS_RATE: s_nxt.rate = req.wdata;
                OFS_PLL_FREQ: s_nxt.freq = req.wdata;
                OFS_DIVS: s_nxt.divs = req.wdata;
                OFS_IRQ_STAT: clr = req.wdata[2:0];
                OFS_IRQ_MASK: s_nxt.imask = req.wdata[2:0];
                default: s_nxt.ctrl = s_r.ctrl;
            endcase
        end

        // A rejected request leaves the running clock plan untouched.
        s_nxt.retime = 1'b0;
        if (apply) begin
            if (check_err) begin
                ev[IRQ_ERR] = 1'b1;
            end else begin
                s_nxt.hp_sel = use_hp;
                s_nxt.act_rate = s_r.rate;
                s_nxt.act_freq = new_freq;
                s_nxt.cfg_ok = 1'b1;
                s_nxt.retime = 1'b1;
                ev[IRQ_DONE] = 1'b1;
            end
        end

        // Sample the sync pin every reference cycle; count detected pulses.
        s_nxt.samp1 = SYNC_I;
        s_nxt.samp2 = s_r.samp1;
        s_nxt.sync_prev = sync_sel;
        if (sync_rise) begin
            s_nxt.sync_cnt = s_r.sync_cnt + 3'd1;
            ev[IRQ_SYNC] = 1'b1;
        end
        if (!mcs_active) begin
            s_nxt.sync_cnt = 3'd0;
        end

        // Sticky status: an event in the clearing cycle still sets its bit.
        s_nxt.ist = (s_r.ist & ~clr) | ev;
        s_nxt.irq = |(s_nxt.ist & s_nxt.imask);
    end

    // State register.
    always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            s_r <= '{ctrl: CTRL_RST, rate: RATE_RST, freq: LP_FIX_KHZ, divs: DIVS_RST,
                     ist: 3'b000, imask: 3'b000, hp_sel: 1'b0, cfg_ok: 1'b0,
                     act_rate: RATE_RST, act_freq: LP_FIX_KHZ, sync_cnt: 3'd0,
                     samp1: 1'b0, samp2: 1'b0, sync_prev: 1'b0, retime: 1'b0,
                     pready: 1'b0, pslverr: 1'b0, prdata: 32'h0000_0000, irq: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    // Converter clock enable of the clock generator.
    ccp_divider #(
        .W(DIV_W)
    ) u_conv_div (
        .clk_i(REF_CLK_I),
        .rst_n_i(RESET_N_I),
        .ratio_i(s_r.divs[DIV_W-1:0]),
        .align_i(align),
        .en_o(conv_en)
    );

    // Main digital clock enable of the clock generator.
    ccp_divider #(
        .W(DIV_W)
    ) u_dig_div (
        .clk_i(REF_CLK_I),
        .rst_n_i(RESET_N_I),
        .ratio_i(s_r.divs[DIVS_DIG_LSB +: DIV_W]),
        .align_i(align),
        .en_o(dig_en)
    );

    // Outputs come straight from flip-flops.
    assign PRDATA_O = s_r.prdata;
    assign PREADY_O = s_r.pready;
    assign PSLVERR_O = s_r.pslverr;
    assign HP_PLL_SEL_O = s_r.hp_sel;
    assign IRQ_O = s_r.irq;
    assign CONV_CLK_EN_O = conv_en;
    assign DIG_CLK_EN_O = dig_en;

endmodule

// [ccp_pkg.sv]
// Shared constants and types of the clock plan and sync capture block.
// Assumes a 20 MHz reference clock and an APB register bus with 32-bit data.
package ccp_pkg;

    // Register byte offsets.
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_RATE = 8'h04;
    localparam logic [7:0] OFS_PLL_FREQ = 8'h08;
    localparam logic [7:0] OFS_DIVS = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
    localparam logic [7:0] OFS_APPLY = 8'h1c;
    localparam logic [7:0] OFS_ACT_RATE = 8'h20;
    localparam logic [7:0] OFS_ACT_FREQ = 8'h24;

    // Control and divider register field positions.
    localparam int CTRL_TUNE_EN = 0;
    localparam int CTRL_FORCE_LP = 1;
    localparam int CTRL_BITS16 = 2;
    localparam int CTRL_LVDS = 3;
    localparam int CTRL_MCS_EN = 4;
    localparam int CTRL_SYNC_FALL = 5;
    localparam int CTRL_ARB_RATE = 6;
    localparam int CTRL_SER_LSB = 8;
    localparam int DIVS_DIG_LSB = 16;

    // Interrupt status bit positions.
    localparam int IRQ_DONE = 0;
    localparam int IRQ_ERR = 1;
    localparam int IRQ_SYNC = 2;

    // Reset values.
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] DIVS_RST = 32'h0001_0001;
    localparam logic [31:0] RATE_RST = 32'h0000_0000;

    // Frequencies in kHz and rates in Hz.
    localparam logic [31:0] HP_MIN_KHZ = 32'd7200000;
    localparam logic [31:0] HP_MAX_KHZ = 32'd8800000;
    localparam logic [31:0] LP_FIX_KHZ = 32'd4423680;
    localparam logic [31:0] LP_MIN_KHZ = 32'd3300000;
    localparam logic [31:0] LP_MAX_KHZ = 32'd5000000;
    localparam logic [31:0] RATE_MIN_HZ = 32'd24000;
    localparam logic [31:0] RATE_MAX_HZ = 32'd61440000;
    localparam logic [31:0] LTE40_HZ = 32'd61440000;
    localparam logic [39:0] LANE_MAX_BPS = 40'd737280000;
    // Three times 160/3 MHz, so the compare needs no division.
    localparam logic [36:0] HP_ONLY_X3_HZ = 37'd160000000;

    // Dead zone bounds scaled by 24 so every bound is a whole number of Hz.
    localparam int DZ_COUNT = 12;
    localparam logic [36:0] DZ_LO_X24 [DZ_COUNT] = '{
        37'd1200000000, 37'd800000000, 37'd600000000, 37'd400000000,
        37'd300000000, 37'd200000000, 37'd150000000, 37'd100000000,
        37'd75000000, 37'd50000000, 37'd37500000, 37'd25000000};
    localparam logic [36:0] DZ_HI_X24 [DZ_COUNT] = '{
        37'd1280000000, 37'd960000000, 37'd640000000, 37'd480000000,
        37'd320000000, 37'd240000000, 37'd160000000, 37'd120000000,
        37'd80000000, 37'd60000000, 37'd40000000, 37'd30000000};

    // APB request as seen by the slave.
    typedef struct packed {
        logic sel;
        logic enable;
        logic write;
        logic [7:0] addr;
        logic [31:0] wdata;
    } ccp_apb_req_s;

endpackage

// [ccp_divider.sv]
// Clock divider of the clock generator: one-cycle enable every ratio cycles.
// Assumes align is a one-cycle pulse in the same clock domain.
`timescale 1ns/1ps
module ccp_divider
    import ccp_pkg::*;
#(
    parameter int W = 16
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [W-1:0] ratio_i,
    input wire logic align_i,
    output logic en_o
);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic en;
    } ccp_div_state_s;

    ccp_div_state_s s_r;
    ccp_div_state_s s_nxt;
    logic [W-1:0] last;

    // A ratio of zero behaves as one, so the enable never stalls forever.
    always_comb begin
        s_nxt = s_r;
        last = (ratio_i == '0) ? '0 : ratio_i - W'(1);
        if (align_i) begin
            // Restart the phase so every divider counts from the same edge.
            s_nxt.cnt = '0;
            s_nxt.en = 1'b0;
        end else if (s_r.cnt >= last) begin
            s_nxt.cnt = '0;
            s_nxt.en = 1'b1;
        end else begin
            s_nxt.cnt = s_r.cnt + W'(1);
            s_nxt.en = 1'b0;
        end
    end

    // State register.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign en_o = s_r.en;

endmodule

// [ccp_clock_plan_props.sv]
// Concurrent checks for the clock plan block, bound to its top module.
// Assumes a single clock domain on REF_CLK_I and APB with no wait states.
`timescale 1ns/1ps
module ccp_clock_plan_props
    import ccp_pkg::*;
(
    input wire logic REF_CLK_I,
    input wire logic RESET_N_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic PREADY_O,
    input wire logic PSLVERR_O,
    input wire logic SYNC_I,
    input wire logic CONV_CLK_EN_O,
    input wire logic DIG_CLK_EN_O,
    input wire logic HP_PLL_SEL_O,
    input wire logic IRQ_O
);
    logic [31:0] ctrl_q;
    logic [31:0] rate_q;
    logic [3:0] wr_age;
    logic [3:0] sync_age;
    logic wr_done;
    logic lp_case;
    // A completed write; shadows follow it so rate and mode are known here.
    assign wr_done = PSEL_I && PENABLE_I && PWRITE_I && PREADY_O;
    assign lp_case = ctrl_q[CTRL_FORCE_LP] && !ctrl_q[CTRL_BITS16] && rate_q == LTE40_HZ;
    // Ages saturate so a long quiet stretch cannot wrap into a false cause.
    always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            ctrl_q <= CTRL_RST;
            rate_q <= RATE_RST;
            wr_age <= 4'hf;
            sync_age <= 4'hf;
        end else begin
            if (wr_done && PADDR_I == OFS_CTRL) ctrl_q <= PWDATA_I;
            if (wr_done && PADDR_I == OFS_RATE) rate_q <= PWDATA_I;
            wr_age <= wr_done ? 4'h0 : (wr_age == 4'hf ? wr_age : wr_age + 4'h1);
            if (SYNC_I && ctrl_q[CTRL_LVDS] && ctrl_q[CTRL_MCS_EN]) sync_age <= 4'h0;
            else if (sync_age != 4'hf) sync_age <= sync_age + 4'h1;
        end
    end
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!RESET_N_I);
    setup_ready_a: assert property ((PSEL_I && !PENABLE_I) |=> PREADY_O ##1 !PREADY_O)
        else $error("ready not a single pulse after setup");
    ready_cause_a: assert property (PREADY_O |-> $past(PSEL_I && !PENABLE_I))
        else $error("ready without setup");
    rdata_idle_a: assert property (!PREADY_O |-> PRDATA_O == 32'h0)
        else $error("read data outside access");
    slverr_map_a: assert property (PREADY_O |->
        PSLVERR_O == (PADDR_I[1:0] != 2'h0 || PADDR_I > OFS_ACT_FREQ))
        else $error("slave error does not match map");
    hpsel_apply_a: assert property ($changed(HP_PLL_SEL_O) |->
        $past(wr_done && PADDR_I == OFS_APPLY && PWDATA_I[0]))
        else $error("source changed without apply");
    hp_rate_a: assert property ($changed(HP_PLL_SEL_O) |->
        HP_PLL_SEL_O == (37'(rate_q) * 37'h3 > HP_ONLY_X3_HZ && !lp_case))
        else $error("source does not match rate");
    irq_rise_a: assert property ($rose(IRQ_O) |->
        wr_age <= 4'h3 || sync_age <= 4'h6)
        else $error("interrupt rose without cause");
    irq_fall_a: assert property ($fell(IRQ_O) |-> wr_age <= 4'h3)
        else $error("interrupt fell without write");
    cover property ($rose(HP_PLL_SEL_O));
    cover property ($rose(IRQ_O) && wr_age > 4'h3);
    cover property (PSLVERR_O);
endmodule

bind ccp_clock_plan ccp_clock_plan_props u_props (.REF_CLK_I(REF_CLK_I),
    .RESET_N_I(RESET_N_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I),
    .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
    .PSLVERR_O(PSLVERR_O), .SYNC_I(SYNC_I), .CONV_CLK_EN_O(CONV_CLK_EN_O),
    .DIG_CLK_EN_O(DIG_CLK_EN_O), .HP_PLL_SEL_O(HP_PLL_SEL_O), .IRQ_O(IRQ_O));

// [ccp_sync_src.sv]
// Behavioural model of the external clock chip that sends sync pulses.
// Assumes it shares the reference clock with the device under test.
`timescale 1ns/1ps
module ccp_sync_src (
    input wire logic clk_i,
    input wire logic start_i,
    input wire logic [2:0] count_i,
    output logic sync_o,
    output logic busy_o
);
    // Waits are just above the minimum at 20 MHz, so the device sees the worst case.
    localparam int PULSE_W = 2;
    localparam int SHORT_W = 21;
    localparam int LONG_W = 2001;
    initial begin
        sync_o = 1'b0;
        busy_o = 1'b0;
    end
    // Pulses launch just after a rising edge of the shared clock.
    always begin
        @(posedge clk_i);
        if (start_i) begin
            busy_o <= 1'b1;
            for (int p = 1; p <= count_i; p++) begin
                sync_o <= 1'b1;
                repeat (PULSE_W) @(posedge clk_i);
                sync_o <= 1'b0;
                repeat ((p == 4 || p == 5) ? LONG_W : SHORT_W) @(posedge clk_i);
            end
            busy_o <= 1'b0;
        end
    end
endmodule

// [ccp_clock_plan_tb_top.sv]
// Self-checking bench for the clock plan block: APB tasks and sync pulses.
// Assumes the checker is bound to the design and the sync model drives SYNC_I.
`timescale 1ns/1ps
module ccp_clock_plan_tb_top;
    import ccp_pkg::*;
    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] rate;
        logic [31:0] freq;
        logic err;
        logic hp;
    } ccp_case_s;
    // Control, rate, PLL frequency, expected error and expected source.
    localparam ccp_case_s CASES [17] = '{
        '{32'h0, 32'd61440000, 32'd8000000, 1'b0, 1'b1},
        '{32'h0, 32'd61440000, 32'd8800001, 1'b1, 1'b1},
        '{32'h0, 32'd61440000, 32'd7200000, 1'b0, 1'b1},
        '{32'h0c06, 32'd61440000, 32'd8000000, 1'b1, 1'b1},
        '{32'h0c02, 32'd61440000, 32'd8000000, 1'b0, 1'b0},
        '{32'h1002, 32'd61440000, 32'd8000000, 1'b1, 1'b0},
        '{32'h0300, 32'd1000000, 32'h0, 1'b1, 1'b0},
        '{32'h0200, 32'd23999, 32'h0, 1'b1, 1'b0},
        '{32'h0200, 32'd24000, 32'h0, 1'b0, 1'b0},
        '{32'h0240, 32'd51000000, 32'h0, 1'b1, 1'b0},
        '{32'h0240, 32'd50000000, 32'h0, 1'b0, 1'b0},
        '{32'h0240, 32'd1100000, 32'h0, 1'b1, 1'b0},
        '{32'h0200, 32'd53333333, 32'h0, 1'b0, 1'b0},
        '{32'h0, 32'd53333334, 32'd8000000, 1'b0, 1'b1},
        '{32'h0201, 32'd1000000, 32'd3299999, 1'b1, 1'b1},
        '{32'h0201, 32'd1000000, 32'd5000000, 1'b0, 1'b0},
        '{32'h0, 32'd61440001, 32'd8000000, 1'b1, 1'b0}};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0;
    logic start = 1'b0;
    logic [2:0] sync_n = 3'h6;
    logic [31:0] prdata;
    logic pready, pslverr, sync, busy, conv_en, dig_en, hp_sel, irq;
    logic [31:0] q;
    logic [31:0] exp_rate;
    logic e;
    int err_count = 0;
    int checked = 0;
    int n;
    ccp_clock_plan uut (.REF_CLK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel),
        .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .SYNC_I(sync),
        .CONV_CLK_EN_O(conv_en), .DIG_CLK_EN_O(dig_en), .HP_PLL_SEL_O(hp_sel), .IRQ_O(irq));
    ccp_sync_src u_src (.clk_i(clk), .start_i(start), .count_i(sync_n), .sync_o(sync),
        .busy_o(busy));
    // The clock toggles every half period of 25 ns.
    always #25 clk = ~clk;
    task end_sim;
        if (err_count == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; the request holds until ready is seen at an edge.
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (k = 0; k < 16; k++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (k == 16) begin
            err_count++;
            end_sim;
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(q & m, exp);
    endtask
    // Starts the sync model and waits, bounded, until its burst is over.
    task run(input logic [2:0] cnt);
        int k;
        sync_n <= cnt;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        repeat (2) @(posedge clk);
        for (k = 0; k < 6000 && busy !== 1'b0; k++) @(posedge clk);
        if (k == 6000) begin
            err_count++;
            end_sim;
        end
    endtask
    // Main sequence: reset values, map errors, rate checks, sync capture.
    initial begin
        exp_rate = 32'h0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rd(OFS_CTRL, 32'hffffffff, CTRL_RST);
        rd(OFS_PLL_FREQ, 32'hffffffff, LP_FIX_KHZ);
        rd(OFS_ACT_FREQ, 32'hffffffff, LP_FIX_KHZ);
        rd(OFS_DIVS, 32'hffffffff, DIVS_RST);
        rd(OFS_IRQ_MASK, 32'hffffffff, 32'h0);
        rd(OFS_APPLY, 32'hffffffff, 32'h0);
        rd(8'h28, 32'hffffffff, 32'h0);
        chk({31'h0, e}, 32'h1);
        apb(1'b1, 8'h02, 32'h1);
        chk({31'h0, e}, 32'h1);
        apb(1'b1, OFS_IRQ_MASK, 32'h7);
        for (int i = 0; i < 17; i++) begin
            apb(1'b1, OFS_CTRL, CASES[i].ctrl);
            apb(1'b1, OFS_RATE, CASES[i].rate);
            apb(1'b1, OFS_PLL_FREQ, CASES[i].freq);
            apb(1'b1, OFS_APPLY, 32'h1);
            rd(OFS_IRQ_STAT, 32'hff, CASES[i].err ? 32'h2 : 32'h1);
            chk({31'h0, hp_sel}, {31'h0, CASES[i].hp});
            if (!CASES[i].err) exp_rate = CASES[i].rate;
            rd(OFS_ACT_RATE, 32'hffffffff, exp_rate);
            chk({31'h0, irq}, 32'h1);
            apb(1'b1, OFS_IRQ_STAT, 32'h3);
            rd(OFS_IRQ_STAT, 32'hff, 32'h0);
            chk({31'h0, irq}, 32'h0);
        end
        apb(1'b1, OFS_CTRL, 32'h10);
        run(3'h6);
        rd(OFS_STATUS, 32'h78, 32'h0);
        rd(OFS_IRQ_STAT, 32'hff, 32'h0);
        apb(1'b1, OFS_IRQ_MASK, 32'h0);
        apb(1'b1, OFS_CTRL, 32'h18);
        run(3'h6);
        rd(OFS_STATUS, 32'h78, 32'h68);
        rd(OFS_IRQ_STAT, 32'hff, 32'h4);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, OFS_IRQ_MASK, 32'h4);
        rd(OFS_IRQ_MASK, 32'hff, 32'h4);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, OFS_CTRL, 32'h38);
        run(3'h6);
        rd(OFS_STATUS, 32'h78, 32'h48);
        apb(1'b1, OFS_IRQ_STAT, 32'h4);
        rd(OFS_IRQ_STAT, 32'hff, 32'h0);
        chk({31'h0, irq}, 32'h0);
        // Unequal ratios first push the two dividers out of phase.
        apb(1'b1, OFS_DIVS, 32'h0007_0003);
        repeat (5) @(posedge clk);
        apb(1'b1, OFS_DIVS, 32'h0007_0007);
        run(3'h1);
        n = 0;
        for (int k = 0; k < 21; k++) begin
            @(posedge clk);
            chk({31'h0, conv_en}, {31'h0, dig_en});
            if (conv_en === 1'b1) n++;
        end
        chk(n, 32'h3);
        end_sim;
    end
endmodule
